/* File: tocp_timer.sv */
// 16-bit timer with one-shot, continuous and dual-output pwm modes
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - counter wraps FFFF to 0000 without match
// R2 - shortest 0001 prescale 1, longest 0000/128
// R3 - one-shot match: irq, count 0001, disable
// R4 - one-shot pin inverted for one cycle
// R5 - software flips polarity for lasting level
// R6 - software sets up before enabling
// R7 - one-shot timeout (reload-start+1) times prescale
// R8 - continuous match: irq, reload 0001, run
// R9 - continuous pin toggles each reload
// R10 - pwm period reload times prescale
// R11 - dual mode toggles at pwm match
// R12 - polarity one: start high, fall at match
// R13 - polarity zero: start low, rise at match
// R14 - complement pin carries inverse output
// R15 - dead-band delays inactive-to-active edges
// R16 - complement driven only in dual mode
// R17 - input pin shared with primary output
// R18 - dead-band code n gives 2^n cycles, code 0 gives none
// R19 - reload 0000 matches after full wrap
module tocp_timer import tocp_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic timer_input_pin,
	output logic timer_output_pin,
	output logic timer_output_pin_oe,
	output logic timer_output_comp,
	output logic timer_output_comp_oe,
	output logic timer_input_sample,
	output logic irq
);
	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ------------------------------------------------------------
	// registers and bus decode
	// ------------------------------------------------------------
	logic [CTL_W-1:0] ctl_q;
	logic [15:0] count_q;
	logic [15:0] reload_q;
	logic [15:0] pwm_q;
	logic [ST_W-1:0] status_q;
	logic [ST_W-1:0] mask_q;
	logic out_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [3:0] word;
	logic wr_hit;
	logic wr_ctl;
	logic wr_count;
	logic wr_reload;
	logic wr_pwm;
	logic wr_status;
	logic wr_mask;
	logic [31:0] be_mask;
	logic [31:0] rd_mux;
	assign word = avs_address[ADDR_W-1:2];
	// one wait state: the access completes on the edge ack is high
	assign wr_hit = avs_write && ack_q;
	assign wr_ctl = wr_hit && (word == REG_CTRL);
	assign wr_count = wr_hit && (word == REG_COUNT);
	assign wr_reload = wr_hit && (word == REG_RELOAD);
	assign wr_pwm = wr_hit && (word == REG_PWM);
	assign wr_status = wr_hit && (word == REG_STATUS);
	assign wr_mask = wr_hit && (word == REG_MASK);
	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	// unmapped words read as zero, writes to them are dropped
	assign rd_mux = (word == REG_CTRL) ? {20'h00000, ctl_q} :
		(word == REG_COUNT) ? {16'h0000, count_q} :
		(word == REG_RELOAD) ? {16'h0000, reload_q} :
		(word == REG_PWM) ? {16'h0000, pwm_q} :
		(word == REG_STATUS) ? {30'h00000000, status_q} :
		(word == REG_MASK) ? {30'h00000000, mask_q} : 32'h00000000;

	// bus handshake: wait one cycle then answer
	always_ff @(posedge ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ack_q <= 1'b0;
			avs_waitrequest <= 1'b1;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q;
			avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
			rdata_q <= rd_mux;
		end
	end
	assign avs_readdata = rdata_q;

	// ------------------------------------------------------------
	// control field decode
	// ------------------------------------------------------------
	logic enable;
	logic pol;
	logic alt_en;
	logic altc_en;
	tocp_mode_t mode;
	logic [2:0] pre_sel;
	logic [2:0] db_code;
	logic [DB_W:0] db_cycles;
	assign enable = ctl_q[CTL_EN];
	assign mode = tocp_mode_t'(ctl_q[CTL_MODE_LO +: 2]);
	assign pre_sel = ctl_q[CTL_PRE_LO +: 3];
	assign pol = ctl_q[CTL_POL];
	assign alt_en = ctl_q[CTL_ALT];
	assign altc_en = ctl_q[CTL_ALTC];
	assign db_code = ctl_q[CTL_DB_LO +: 3];
	// R18 dead-band code decode
	assign db_cycles = (db_code == 3'h0) ? (DB_W+1)'(0) : (DB_W+1)'(9'h001 << db_code);

	// ------------------------------------------------------------
	// counting events
	// ------------------------------------------------------------
	logic tick;
	logic [15:0] count_inc;
	logic reload_hit;
	logic pwm_hit;
	logic is_dual;
	tocp_prescaler #(
		.PRE_W(7)
	) u_pre (
		.clk(ref_clk),
		.rst_n(rst_sync_q),
		.run(enable),
		.sel(pre_sel),
		.tick(tick)
	);
	// R1 natural 16-bit wrap
	assign count_inc = count_q + 16'h0001;
	// R19 reload 0000 reached only through the wrap
	assign reload_hit = tick && (count_q == reload_q);
	assign pwm_hit = tick && (count_q == pwm_q) && !reload_hit;
	assign is_dual = (mode == TOCP_DUAL);

	// ------------------------------------------------------------
	// counter and control update
	// ------------------------------------------------------------
	logic [CTL_W-1:0] ctl_d;
	logic [15:0] count_d;
	always_comb begin
		ctl_d = ctl_q;
		if (wr_ctl) begin
			ctl_d = (ctl_q & ~be_mask[CTL_W-1:0]) | (avs_writedata[CTL_W-1:0] & be_mask[CTL_W-1:0]);
		end
		count_d = count_q;
		if (wr_count) begin
			count_d = (count_q & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
		end else if (reload_hit) begin
			// R3 R8 R11 restart at 0001 on reload
			count_d = COUNT_RESTART;
		end else if (tick) begin
			// R2 R7 R10 one step per prescaled tick
			count_d = count_inc;
		end
		// R3 one-shot disables itself at reload
		if (reload_hit && (mode == TOCP_ONESHOT) && !wr_ctl) begin
			ctl_d[CTL_EN] = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ctl_q <= CTL_RST;
			count_q <= COUNT_RST;
			reload_q <= RELOAD_RST;
			pwm_q <= PWM_RST;
		end else begin
			ctl_q <= ctl_d;
			count_q <= count_d;
			if (wr_reload) begin
				reload_q <= (reload_q & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
			end
			if (wr_pwm) begin
				pwm_q <= (pwm_q & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
			end
		end
	end

	// ------------------------------------------------------------
	// sticky status and interrupt
	// ------------------------------------------------------------
	logic [ST_W-1:0] ev;
	logic [ST_W-1:0] status_d;
	assign ev = {pwm_hit && is_dual, reload_hit};
	// a new event wins over a write-one clear
	assign status_d = (status_q & ~(wr_status ? avs_writedata[ST_W-1:0] : {ST_W{1'b0}})) | ev;
	always_ff @(posedge ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			status_q <= '0;
			mask_q <= '0;
			irq <= 1'b0;
		end else begin
			status_q <= status_d;
			if (wr_mask) begin
				mask_q <= avs_writedata[ST_W-1:0];
			end
			irq <= |(status_d & (wr_mask ? avs_writedata[ST_W-1:0] : mask_q));
		end
	end

	// ------------------------------------------------------------
	// output waveform
	// ------------------------------------------------------------
	logic out_d;
	logic pulse_q;
	logic raw_out;
	always_comb begin
		out_d = out_q;
		if (!enable) begin
			// idle level follows polarity
			out_d = pol;
		end else if (mode == TOCP_ONESHOT) begin
			// hold while running so a polarity flip lands at the timeout
			if (reload_hit) out_d = pol;
		end else if (mode == TOCP_CONT) begin
			// R9 square wave toggles each reload
			if (reload_hit) out_d = !out_q;
		end else begin
			// R12 R13 back to polarity at reload, flip at match
			if (reload_hit) out_d = pol;
			else if (pwm_hit) out_d = !out_q;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			out_q <= 1'b0;
			pulse_q <= 1'b0;
		end else begin
			out_q <= out_d;
			// R4 single-cycle inversion at one-shot reload
			pulse_q <= reload_hit && (mode == TOCP_ONESHOT);
		end
	end
	assign raw_out = pulse_q ? !pol : out_q;

	// R15 dead-band on both pins in dual mode only; low to high is the inactive-to-active edge
	logic db_out;
	logic db_comp;
	tocp_deadband u_db_out (
		.clk(ref_clk),
		.rst_n(rst_sync_q),
		.raw(raw_out),
		.act_lvl(1'b1),
		.delay(is_dual ? db_cycles : (DB_W+1)'(0)),
		.dout(db_out)
	);
	// R14 complement carries the inverse
	tocp_deadband u_db_comp (
		.clk(ref_clk),
		.rst_n(rst_sync_q),
		.raw(!raw_out),
		.act_lvl(1'b1),
		.delay(db_cycles),
		.dout(db_comp)
	);

	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			timer_output_pin <= 1'b0;
			timer_output_pin_oe <= 1'b0;
			timer_output_comp <= 1'b0;
			timer_output_comp_oe <= 1'b0;
			timer_input_sample <= 1'b0;
		end else begin
			timer_output_pin <= db_out;
			// R17 pin is input unless output function enabled
			timer_output_pin_oe <= alt_en;
			timer_input_sample <= timer_input_pin;
			// R16 complement only in dual mode
			timer_output_comp <= is_dual ? db_comp : 1'b0;
			timer_output_comp_oe <= is_dual && altc_en;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_oneshot_reload;
		reload_hit && mode == TOCP_ONESHOT && !wr_ctl && !wr_count;
	endsequence
	a_oneshot_stop: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // R3
		s_oneshot_reload |=> (!enable && count_q == 16'h0001))
		else $error("one-shot did not stop at 0001");
	a_cont_restart: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // R8
		(reload_hit && mode == TOCP_CONT && !wr_ctl && !wr_count) |=> (enable && count_q == 16'h0001))
		else $error("continuous did not restart");
	a_wrap_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // R1
		(tick && count_q == 16'hFFFF && reload_q != 16'hFFFF && !wr_count) |=> count_q == 16'h0000)
		else $error("counter did not wrap");
	a_square_toggle: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // R9
		(reload_hit && mode == TOCP_CONT && enable && !wr_ctl) |=> out_q != $past(out_q))
		else $error("square wave missed toggle");
	a_pwm_restore: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // R12
		(reload_hit && is_dual && !wr_ctl) |=> out_q == pol)
		else $error("pwm level not restored");
	a_pulse_width: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // R4
		s_oneshot_reload |=> pulse_q ##1 !pulse_q)
		else $error("one-shot pulse not one cycle");
	a_comp_idle: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // R16
		!is_dual |=> !timer_output_comp_oe && !timer_output_comp)
		else $error("complement driven outside dual");
	a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // R3
		(reload_hit && mask_q[ST_RELOAD] && !wr_mask) |=> irq)
		else $error("reload did not raise irq");
	a_match_toggle: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // R11
		(pwm_hit && is_dual && !wr_ctl) |=> out_q != $past(out_q))
		else $error("pwm match did not toggle output");
	a_match_status: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // R11
		(pwm_hit && is_dual) |=> status_q[ST_MATCH])
		else $error("pwm match not flagged");
	a_pwm_low_start: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // R13
		(reload_hit && is_dual && !pol && !wr_ctl) |=> !out_q)
		else $error("pwm did not return low");
	a_pins_exclusive: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // R15
		!(timer_output_pin && timer_output_comp))
		else $error("output and complement high together");
endmodule
`default_nettype wire

/* File: tocp_pkg.sv */
// shared constants for the one-shot / continuous / pwm timer
package tocp_pkg;
	// ----------------------------------------------------------------
	// register map (word indices; byte address is index times 4)
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_COUNT = 4'h1;
	localparam logic [3:0] REG_RELOAD = 4'h2;
	localparam logic [3:0] REG_PWM = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_MASK = 4'h5;
	localparam int ADDR_W = 6;
	// ----------------------------------------------------------------
	// control field positions
	// ----------------------------------------------------------------
	localparam int CTL_EN = 0;
	localparam int CTL_MODE_LO = 1;
	localparam int CTL_PRE_LO = 3;
	localparam int CTL_POL = 6;
	localparam int CTL_ALT = 7;
	localparam int CTL_ALTC = 8;
	localparam int CTL_DB_LO = 9;
	localparam int CTL_W = 12;
	// ----------------------------------------------------------------
	// status bits
	// ----------------------------------------------------------------
	localparam int ST_RELOAD = 0;
	localparam int ST_MATCH = 1;
	localparam int ST_W = 2;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] COUNT_RST = 16'h0001;
	localparam logic [15:0] RELOAD_RST = 16'h0000;
	localparam logic [15:0] PWM_RST = 16'h0000;
	localparam logic [15:0] COUNT_RESTART = 16'h0001;
	localparam logic [11:0] CTL_RST = 12'h000;
	localparam int PRE_MAX = 128;
	localparam int DB_MAX = 128;
	localparam int DB_W = 8;
	// ----------------------------------------------------------------
	// modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TOCP_ONESHOT = 2'h0,
		TOCP_CONT = 2'h1,
		TOCP_DUAL = 2'h3
	} tocp_mode_t;
endpackage

/* File: tocp_prescaler.sv */
// power-of-two prescaler producing one tick per divided period
`timescale 1ns/1ps
`default_nettype none
module tocp_prescaler import tocp_pkg::*; #(
	parameter int PRE_W = 7
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [2:0] sel,
	output logic tick
);
	logic [PRE_W-1:0] cnt_q;
	logic [PRE_W-1:0] last;
	logic wrap;
	// ------------------------------------------------------------
	// terminal count 2^sel - 1
	// ------------------------------------------------------------
	assign last = PRE_W'((8'h01 << sel) - 8'h01);
	assign wrap = (cnt_q == last);
	assign tick = run && wrap;
	// count while running, restart when idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (!run || wrap) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + PRE_W'(1);
		end
	end
endmodule
`default_nettype wire

/* File: tocp_deadband.sv */
// delays the inactive-to-active edge of one output by a set count
`timescale 1ns/1ps
`default_nettype none
module tocp_deadband import tocp_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic raw,
	input wire logic act_lvl,
	input wire logic [DB_W:0] delay,
	output logic dout
);
	logic [DB_W:0] cnt_q;
	logic wants_active;
	assign wants_active = (raw == act_lvl);
	// count time spent asked-active; pass active only after delay
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			dout <= 1'b0;
		end else if (!wants_active) begin
			cnt_q <= '0;
			dout <= raw;
		end else if (cnt_q >= delay) begin
			dout <= raw;
		end else begin
			cnt_q <= cnt_q + (DB_W+1)'(1);
		end
	end
endmodule
`default_nettype wire

/* File: tocp_load_model.sv */
// load model watching the timer pins and timing their levels
`timescale 1ns/1ps
`default_nettype none
module tocp_load_model (
	input wire logic clk,
	input wire logic out_pin,
	input wire logic comp_pin,
	input wire logic act_lvl,
	input wire logic watch,
	output logic in_pin,
	output int hi_len,
	output int comp_hi,
	output int per_len,
	output int gap,
	output int overlap
);
	logic po = 1'h0;
	logic pc = 1'h0;
	int ro = 0;
	int rc = 0;
	int rs = 0;
	initial begin
		in_pin = 1'h0;
		{hi_len, comp_hi, per_len, gap, overlap} = '0;
	end
	// ------------------------------------------------------------
	// run lengths of each pin level
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (out_pin !== po) begin
			gap <= ro;
			if (po) hi_len <= ro;
			ro = 1;
		end else ro++;
		if (comp_pin !== pc) begin
			if (pc) comp_hi <= rc;
			rc = 1;
		end else rc++;
		if (out_pin && !po) begin
			per_len <= rs;
			rs = 1;
		end else rs++;
		if (watch && out_pin === act_lvl && comp_pin === act_lvl) overlap <= overlap + 1;
		po = out_pin;
		pc = comp_pin;
		// input line keeps changing every cycle
		in_pin <= ~in_pin;
	end
endmodule
`default_nettype wire

/* File: tocp_timer_bench.sv */
// self-checking bench for the timer over its register bus
`timescale 1ns/1ps
`default_nettype none
module tocp_timer_bench import tocp_pkg::*;;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic watch = 1'h0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, timer_input_pin, timer_output_pin, timer_output_pin_oe;
	logic timer_output_comp, timer_output_comp_oe, timer_input_sample, irq;
	int hi_len, comp_hi, per_len, gap, overlap, a, b, d;
	int n_errors = 0;
	int compares = 0;
	// ------------------------------------------------------------
	// clock, design and load
	// ------------------------------------------------------------
	always #50 ref_clk = ~ref_clk;
	tocp_timer dut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .timer_input_pin, .timer_output_pin,
		.timer_output_pin_oe, .timer_output_comp, .timer_output_comp_oe, .timer_input_sample, .irq);
	tocp_load_model load (.clk(ref_clk), .out_pin(timer_output_pin), .comp_pin(timer_output_comp),
		.act_lvl(1'h1), .watch, .in_pin(timer_input_pin), .hi_len, .comp_hi, .per_len, .gap, .overlap);
	// ------------------------------------------------------------
	// bus, compare and report tasks
	// ------------------------------------------------------------
	task automatic fail(input string m);
		n_errors++;
		$display("ERROR at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) fail($sformatf("got %h expected %h", g, e));
	endtask
	task automatic bus(input logic w, input logic [3:0] r, input logic [31:0] v);
		int k;
		@(posedge ref_clk);
		avs_address <= {r, 2'h0};
		avs_writedata <= v;
		avs_write <= w;
		avs_read <= ~w;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (avs_waitrequest !== 1'h0 && k < 50);
		if (k >= 50) fail("no bus answer");
		rd = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task automatic wr(input logic [3:0] r, input logic [31:0] v);
		bus(1'h1, r, v);
	endtask
	task automatic rdc(input logic [3:0] r, input logic [31:0] e);
		bus(1'h0, r, 32'h0);
		chk(rd, e);
	endtask
	function automatic logic [31:0] ctl(input logic en, input logic [1:0] md, input logic [2:0] pr,
		input logic pl, input logic ac, input logic [2:0] db);
		ctl = '0;
		ctl[CTL_EN] = en;
		ctl[CTL_MODE_LO+:2] = md;
		ctl[CTL_PRE_LO+:3] = pr;
		ctl[CTL_POL] = pl;
		ctl[CTL_ALT] = 1'h1;
		ctl[CTL_ALTC] = ac;
		ctl[CTL_DB_LO+:3] = db;
	endfunction
	// disable, mode, count, reload, interrupt, then enable
	task automatic setup(input logic [31:0] c, input logic [15:0] st, input logic [15:0] rl, input logic [15:0] pw);
		wr(REG_CTRL, c);
		wr(REG_COUNT, {16'h0, st});
		wr(REG_RELOAD, {16'h0, rl});
		wr(REG_PWM, {16'h0, pw});
		wr(REG_STATUS, 32'h3);
		wr(REG_CTRL, c | 32'h1);
	endtask
	task automatic oneshot(input logic [15:0] st, input logic [15:0] rl, input logic [2:0] pr, output int cyc);
		wr(REG_MASK, 32'h1);
		setup(ctl(1'h0, TOCP_ONESHOT, pr, 1'h0, 1'h0, 3'h0), st, rl, 16'h0);
		cyc = 0;
		while (irq !== 1'h1 && cyc < 3000) begin
			@(posedge ref_clk);
			cyc++;
		end
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic pwm(input logic pl, input logic [2:0] db);
		watch <= 1'h0;
		setup(ctl(1'h0, TOCP_DUAL, 3'h0, pl, 1'h1, db), 16'h1, 16'h200, 16'h0C0);
		repeat (600) @(posedge ref_clk);
		watch <= 1'h1;
		repeat (1100) @(posedge ref_clk);
	endtask
	task automatic wrap_up;
		$display("counts: %0d compares, %0d errors", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge ref_clk);
		rdc(REG_COUNT, 32'h1);
		rdc(REG_CTRL, 32'h0);
		wr(4'hF, 32'hFFFF);
		rdc(4'hF, 32'h0);
		$display("test reset done");
		oneshot(16'h1, 16'h5, 3'h0, a);
		chk(gap, 32'h1);
		rdc(REG_COUNT, 32'h1);
		rdc(REG_CTRL, ctl(1'h0, TOCP_ONESHOT, 3'h0, 1'h0, 1'h0, 3'h0));
		rdc(REG_STATUS, 32'h1);
		chk(irq, 1'h1);
		wr(REG_STATUS, 32'h1);
		rdc(REG_STATUS, 32'h0);
		chk(irq, 1'h0);
		oneshot(16'h3, 16'h5, 3'h0, b);
		chk(a - b, 32'h2);
		oneshot(16'hFFFE, 16'h2, 3'h0, b);
		chk(b, a);
		oneshot(16'hFFFC, 16'h0, 3'h0, b);
		chk(b, a);
		oneshot(16'h0, 16'h1, 3'h0, b);
		chk(a - b, 32'h3);
		oneshot(16'h1, 16'h5, 3'h2, a);
		oneshot(16'h3, 16'h5, 3'h2, b);
		chk(a - b, 32'h8);
		setup(ctl(1'h0, TOCP_ONESHOT, 3'h0, 1'h0, 1'h0, 3'h0), 16'h1, 16'h40, 16'h0);
		wr(REG_CTRL, ctl(1'h1, TOCP_ONESHOT, 3'h0, 1'h1, 1'h0, 3'h0));
		repeat (4) @(posedge ref_clk);
		chk(timer_output_pin, 1'h0);
		repeat (80) @(posedge ref_clk);
		chk(timer_output_pin, 1'h1);
		$display("test oneshot done");
		wr(REG_MASK, 32'h0);
		setup(ctl(1'h0, TOCP_CONT, 3'h1, 1'h0, 1'h0, 3'h0), 16'h1, 16'h4, 16'h0);
		repeat (60) @(posedge ref_clk);
		chk(irq, 1'h0);
		rdc(REG_STATUS, 32'h1);
		wr(REG_MASK, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'h1);
		chk(gap, 32'h8);
		rdc(REG_CTRL, ctl(1'h1, TOCP_CONT, 3'h1, 1'h0, 1'h0, 3'h0));
		chk({timer_output_comp, timer_output_comp_oe}, 2'h0);
		chk(timer_output_pin_oe, 1'h1);
		chk(timer_input_sample, !timer_input_pin);
		$display("test continuous done");
		for (int i = 0; i < 8; i++) begin
			pwm(1'h0, i[2:0]);
			d = (i == 0) ? 0 : (1 << i);
			chk(hi_len, 32'h140 - d);
			chk(comp_hi, 32'h0C0 - d);
		end
		pwm(1'h1, 3'h0);
		chk(hi_len, 32'h0C0);
		chk(per_len, 32'h200);
		chk(timer_output_comp, !timer_output_pin);
		chk(timer_output_comp_oe, 1'h1);
		chk(overlap, 32'h0);
		rdc(REG_STATUS, 32'h3);
		$display("test dual done");
		wrap_up();
	end
	// watchdog cuts a hung run short
	initial begin
		#4000000;
		fail("watchdog expired");
		wrap_up();
	end
endmodule
`default_nettype wire
